/* rtl/tag_regs_pkg.sv */
// Constants, register map and carrier types for the host register group.
// Assumes a 40 MHz pclk and an APB master with 32-bit data and pstrb.
package tag_regs_pkg;
	// ----------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------
	localparam logic [15:0] IDX_FIRMWARE_VERSION   = 16'hffee;
	localparam logic [15:0] IDX_COMM_WATCHDOG      = 16'hfff0;
	localparam logic [15:0] IDX_CHECKSUM_START     = 16'hfff2;
	localparam logic [15:0] IDX_CHECKSUM_LENGTH    = 16'hfff4;
	localparam logic [15:0] IDX_CHECKSUM_RESULT    = 16'hfff6;
	localparam logic [15:0] IDX_INTERRUPT_FLAGS    = 16'hfff8;
	localparam logic [15:0] IDX_INTERRUPT_ENABLE   = 16'hfffa;
	localparam logic [15:0] IDX_BLOCK_STATUS       = 16'hfffc;
	localparam int          ADDR_W                 = 18;

	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int          BIT_CHECKSUM_DONE      = 3;
	localparam int          BIT_PARITY_ERROR       = 4;
	localparam int          BIT_TYPE4_REQUEST      = 5;
	localparam int          BIT_FIELD_LOST         = 6;
	localparam int          BIT_GENERIC_ERROR      = 7;
	localparam int          BIT_READ_PREFETCH      = 8;
	localparam logic [15:0] IRQ_BITS_MASK          = 16'h01f8;
	localparam logic [15:0] WDT_CTRL_MASK          = 16'h000f;
	localparam int          BIT_WDT_ENABLE         = 0;
	localparam int          BIT_STATUS_ACTIVE      = 0;
	localparam int          BIT_STATUS_FRONT_END   = 1;
	localparam logic [2:0]  WDT_SEL_2S             = 3'h0;
	localparam logic [2:0]  WDT_SEL_32S            = 3'h1;
	localparam logic [2:0]  WDT_SEL_8M5            = 3'h2;

	// ----------------------------------------
	// Reset values and checksum constants
	// ----------------------------------------
	localparam logic [15:0] RESET_ZERO16           = 16'h0000;
	localparam logic [15:0] CRC_PRESET             = 16'hffff;
	localparam logic [15:0] CRC_POLY               = 16'h1021;
	localparam logic [15:0] EVEN_MASK              = 16'hfffe;
	localparam logic [7:0]  VERSION_MAJOR_DEFAULT  = 8'h05; // Arbitrary value
	localparam logic [7:0]  VERSION_MINOR_DEFAULT  = 8'h03; // Arbitrary value

	// ----------------------------------------
	// Timing: low-frequency tick and watchdog periods
	// ----------------------------------------
	localparam longint      CLK_HZ                 = 40000000;
	localparam longint      LF_OSC_HZ              = 256000;
	localparam logic [7:0]  LF_DIV_CYCLES          = 8'((CLK_HZ / LF_OSC_HZ));
	localparam longint      WDT_SHORT_MS           = 2000;
	localparam longint      WDT_MEDIUM_MS          = 32000;
	localparam longint      WDT_LONG_MS            = 510000;
	localparam int          WDT_CNT_W              = 28;
	localparam logic [WDT_CNT_W-1:0] WDT_SHORT_TICKS  =
		WDT_CNT_W'((WDT_SHORT_MS * LF_OSC_HZ) / 1000);
	localparam logic [WDT_CNT_W-1:0] WDT_MEDIUM_TICKS =
		WDT_CNT_W'((WDT_MEDIUM_MS * LF_OSC_HZ) / 1000);
	localparam logic [WDT_CNT_W-1:0] WDT_LONG_TICKS   =
		WDT_CNT_W'((WDT_LONG_MS * LF_OSC_HZ) / 1000);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		CRC_IDLE = 3'b001,
		CRC_ADDR = 3'b010,
		CRC_DATA = 3'b100
	} crc_state_t;

	// Events and levels from the protocol engine, same clock
	typedef struct packed {
		logic parity_error;     // Pulse: block parity mismatch seen
		logic parity_mode_on;   // Level: parity-protected mode enabled
		logic transfer_ok;      // Level: current host transfer passed parity
		logic type4_request;    // Pulse: command needs host service
		logic app_select;       // Pulse: tag application select received
		logic field_present;    // Level: field is present
		logic generic_fault;    // Pulse: device unreliable or stopped
		logic read_prefetch;    // Pulse: read serviced, transmission begun
	} engine_events_t;

	// Checksum memory read port
	typedef struct packed {
		logic        rd_en;
		logic [15:0] addr;
	} mem_req_t;
endpackage : tag_regs_pkg

/* rtl/host_irq_crc_watchdog_regs.sv */
// Host register group: interrupt flags, checksum engine, watchdog, version.
// Assumes an APB master on pclk, engine events on the same clock, and a
// message memory that returns a byte one cycle after its read request.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Flag bit 4 reads one while a parity error interrupt is pending.
// - Flag bit 3 reads one while a checksum completion is pending.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - Flag bits 2 to 0 are reserved, read zero; host writes zeros.
// - Checksum completion interrupt rises when result is already readable.
// - Parity error interrupt rises only while parity mode is enabled.
// - Type-4 request interrupt rises when a command needs host service.
// - Field-lost interrupt rises on field loss after an application select.
// - Generic error interrupt rises on any fault making the device unreliable.
// - Read-prefetch interrupt rises once a read is serviced and transmission starts.
// - Writing the length upper byte starts a 16-bit checksum over the range.
// - Length and start address are even; bit 0 forced to zero.
// - Checksum-active status bit is one while the calculation runs.
// - On completion the flag sets and the result register holds the checksum.
// - Checksum uses polynomial x16+x12+x5+1 preset to all ones.
// - Enabled watchdog resets the device without host access within the period.
// - In parity mode only transfers passing parity restart the watchdog.
// - Timeout field bits 3 to 1 select 2 s, 32 s or 8.5 min.
// - Watchdog register bit 0 enables it; resets to disabled.
// - Watchdog periods come from a 256 kHz low-frequency tick.
// - Version register holds major in bits 15-8, minor in bits 7-0.
// - Enabled pending flags are ORed onto the interrupt output.
module host_irq_crc_watchdog_regs #(
	parameter logic [7:0]  VERSION_MAJOR = tag_regs_pkg::VERSION_MAJOR_DEFAULT,
	parameter logic [7:0]  VERSION_MINOR = tag_regs_pkg::VERSION_MINOR_DEFAULT,
	parameter logic [tag_regs_pkg::WDT_CNT_W-1:0] WDT_SHORT_TICKS  =
		tag_regs_pkg::WDT_SHORT_TICKS,
	parameter logic [tag_regs_pkg::WDT_CNT_W-1:0] WDT_MEDIUM_TICKS =
		tag_regs_pkg::WDT_MEDIUM_TICKS,
	parameter logic [tag_regs_pkg::WDT_CNT_W-1:0] WDT_LONG_TICKS   =
		tag_regs_pkg::WDT_LONG_TICKS
) (
	input  wire logic                              pclk,            // Bus clock
	input  wire logic                              presetn,         // Async reset, low
	input  wire logic                              psel,            // APB select
	input  wire logic                              penable,         // APB access phase
	input  wire logic                              pwrite,          // APB direction
	input  wire logic [tag_regs_pkg::ADDR_W-1:0]   paddr,           // APB byte address
	input  wire logic [31:0]                       pwdata,          // APB write data
	input  wire logic [3:0]                        pstrb,           // APB byte strobes
	output logic      [31:0]                       prdata,          // APB read data
	output logic                                   pready,          // APB ready
	output logic                                   pslverr,         // APB error
	input  wire tag_regs_pkg::engine_events_t      events,          // Engine events
	input  wire logic                              contactless_front_end_on, // Front end on
	output tag_regs_pkg::mem_req_t                 mem_req,         // Memory read request
	input  wire logic [7:0]                        mem_rdata,       // Byte, one cycle later
	output logic                                   irq_out,         // Interrupt pin level
	output logic                                   device_reset     // Watchdog reset pulse
);

	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		tag_regs_pkg::crc_state_t       fsm;
		logic [15:0]                    flags;
		logic [15:0]                    irq_en;
		logic [3:0]                     wdt_ctrl;
		logic [15:0]                    crc_start;
		logic [15:0]                    crc_len;
		logic [15:0]                    crc_result;
		logic [15:0]                    crc_work;
		logic [15:0]                    crc_addr;
		logic [15:0]                    crc_left;
		logic                           mem_rd;
		logic [7:0]                     lf_div;
		logic [tag_regs_pkg::WDT_CNT_W-1:0] wdt_cnt;
		logic                           app_selected;
		logic                           field_q;
		logic [31:0]                    rdata;
		logic                           irq;
		logic                           dev_reset;
	} regs_t;

	regs_t state_reg;
	regs_t state_next;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// One byte through the CCITT checksum, most significant bit first
	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		logic        fb;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0} ^ (fb ? tag_regs_pkg::CRC_POLY : 16'h0000);
		end
		return c;
	endfunction : crc_byte

	// Register index from a byte address; valid only when word aligned
	function automatic logic [15:0] reg_index(input logic [tag_regs_pkg::ADDR_W-1:0] a);
		return a[tag_regs_pkg::ADDR_W-1:2];
	endfunction : reg_index

	function automatic logic mapped(input logic [tag_regs_pkg::ADDR_W-1:0] a);
		logic [15:0] i;
		i = reg_index(a);
		return (a[1:0] == 2'b00) && !i[0] && (i >= tag_regs_pkg::IDX_FIRMWARE_VERSION) &&
			(i <= tag_regs_pkg::IDX_BLOCK_STATUS);
	endfunction : mapped

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        setup_ph;
	logic        access_done;
	logic        wr_done;
	logic [15:0] idx;
	logic [15:0] wdata16;
	logic [15:0] lane_mask;
	logic [15:0] rd_value;
	logic        wdt_expired;
	logic [tag_regs_pkg::WDT_CNT_W-1:0] wdt_limit;
	logic [15:0] set_mask;

	// Setup phase captures read data so the access phase answers at once
	assign setup_ph    = psel & ~penable;
	assign access_done = psel & penable;
	assign wr_done     = access_done & pwrite & mapped(paddr);
	assign idx         = reg_index(paddr);
	assign wdata16     = pwdata[15:0];
	assign lane_mask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign pready      = access_done;
	assign pslverr     = access_done & ~mapped(paddr);
	assign prdata      = state_reg.rdata;
	assign mem_req     = '{rd_en: state_reg.mem_rd, addr: state_reg.crc_addr};
	assign irq_out     = state_reg.irq;
	assign device_reset = state_reg.dev_reset;

	// Read multiplexer; reserved bits read zero
	always_comb begin
		rd_value = 16'h0000;
		case (idx)
			tag_regs_pkg::IDX_FIRMWARE_VERSION: rd_value = {VERSION_MAJOR, VERSION_MINOR};
			tag_regs_pkg::IDX_COMM_WATCHDOG:    rd_value = {12'h000, state_reg.wdt_ctrl};
			tag_regs_pkg::IDX_CHECKSUM_START:   rd_value = state_reg.crc_start;
			tag_regs_pkg::IDX_CHECKSUM_LENGTH:  rd_value = state_reg.crc_len;
			tag_regs_pkg::IDX_CHECKSUM_RESULT:  rd_value = state_reg.crc_result;
			tag_regs_pkg::IDX_INTERRUPT_FLAGS:  rd_value = state_reg.flags & tag_regs_pkg::IRQ_BITS_MASK;
			tag_regs_pkg::IDX_INTERRUPT_ENABLE: rd_value = state_reg.irq_en;
			tag_regs_pkg::IDX_BLOCK_STATUS: begin
				rd_value[tag_regs_pkg::BIT_STATUS_ACTIVE]    = (state_reg.fsm != tag_regs_pkg::CRC_IDLE);
				rd_value[tag_regs_pkg::BIT_STATUS_FRONT_END] = contactless_front_end_on;
			end
			default: rd_value = 16'h0000;
		endcase
	end

	// Watchdog period from the timeout field; reserved codes use the shortest
	always_comb begin
		case (state_reg.wdt_ctrl[3:1])
			tag_regs_pkg::WDT_SEL_32S: wdt_limit = WDT_MEDIUM_TICKS;
			tag_regs_pkg::WDT_SEL_8M5: wdt_limit = WDT_LONG_TICKS;
			default:                   wdt_limit = WDT_SHORT_TICKS;
		endcase
	end

	assign wdt_expired = state_reg.wdt_ctrl[tag_regs_pkg::BIT_WDT_ENABLE] &&
		(state_reg.lf_div == 8'h00) && (state_reg.wdt_cnt >= wdt_limit - 1'b1);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.dev_reset = 1'b0;
		state_next.mem_rd = 1'b0;
		set_mask = 16'h0000;
		if (setup_ph) begin
			state_next.rdata = {16'h0000, rd_value};
		end

		// Register writes honour byte strobes; reserved bits stay zero
		if (wr_done) begin
			case (idx)
				tag_regs_pkg::IDX_COMM_WATCHDOG:
					state_next.wdt_ctrl = ((state_reg.wdt_ctrl & ~lane_mask[3:0]) |
						(wdata16[3:0] & lane_mask[3:0])) & tag_regs_pkg::WDT_CTRL_MASK[3:0];
				tag_regs_pkg::IDX_CHECKSUM_START:
					state_next.crc_start = ((state_reg.crc_start & ~lane_mask) |
						(wdata16 & lane_mask)) & tag_regs_pkg::EVEN_MASK;
				tag_regs_pkg::IDX_CHECKSUM_LENGTH:
					state_next.crc_len = ((state_reg.crc_len & ~lane_mask) |
						(wdata16 & lane_mask)) & tag_regs_pkg::EVEN_MASK;
				tag_regs_pkg::IDX_INTERRUPT_FLAGS:
					state_next.flags = state_reg.flags &
						~(wdata16 & lane_mask & tag_regs_pkg::IRQ_BITS_MASK);
				tag_regs_pkg::IDX_INTERRUPT_ENABLE:
					state_next.irq_en = ((state_reg.irq_en & ~lane_mask) |
						(wdata16 & lane_mask)) & tag_regs_pkg::IRQ_BITS_MASK;
				default: ;
			endcase
		end

		// Checksum engine
		case (state_reg.fsm)
			tag_regs_pkg::CRC_IDLE: begin
				if (wr_done && idx == tag_regs_pkg::IDX_CHECKSUM_LENGTH && pstrb[1]) begin
					state_next.crc_work = tag_regs_pkg::CRC_PRESET;
					state_next.crc_addr = state_reg.crc_start;
					state_next.crc_left = wdata16 & tag_regs_pkg::EVEN_MASK;
					if ((wdata16 & tag_regs_pkg::EVEN_MASK) == 16'h0000) begin
						state_next.crc_result = tag_regs_pkg::CRC_PRESET;
						set_mask[tag_regs_pkg::BIT_CHECKSUM_DONE] = 1'b1;
					end else begin
						state_next.fsm = tag_regs_pkg::CRC_ADDR;
						state_next.mem_rd = 1'b1;
					end
				end
			end
			tag_regs_pkg::CRC_ADDR: begin
				state_next.fsm = tag_regs_pkg::CRC_DATA;
			end
			tag_regs_pkg::CRC_DATA: begin
				state_next.crc_work = crc_byte(state_reg.crc_work, mem_rdata);
				state_next.crc_addr = state_reg.crc_addr + 16'h0001;
				state_next.crc_left = state_reg.crc_left - 16'h0001;
				if (state_reg.crc_left == 16'h0001) begin
					state_next.crc_result = crc_byte(state_reg.crc_work, mem_rdata);
					set_mask[tag_regs_pkg::BIT_CHECKSUM_DONE] = 1'b1;
					state_next.fsm = tag_regs_pkg::CRC_IDLE;
				end else begin
					state_next.fsm = tag_regs_pkg::CRC_ADDR;
					state_next.mem_rd = 1'b1;
				end
			end
			default: state_next.fsm = tag_regs_pkg::CRC_IDLE;
		endcase

		// Application select is remembered until the field goes away
		state_next.field_q = events.field_present;
		if (events.app_select) begin
			state_next.app_selected = 1'b1;
		end else if (state_reg.field_q && !events.field_present) begin
			state_next.app_selected = 1'b0;
		end

		// Interrupt sources
		set_mask[tag_regs_pkg::BIT_PARITY_ERROR] =
			events.parity_error & events.parity_mode_on;
		set_mask[tag_regs_pkg::BIT_TYPE4_REQUEST] = events.type4_request;
		set_mask[tag_regs_pkg::BIT_FIELD_LOST] = state_reg.app_selected &
			state_reg.field_q & ~events.field_present;
		set_mask[tag_regs_pkg::BIT_GENERIC_ERROR] = events.generic_fault;
		set_mask[tag_regs_pkg::BIT_READ_PREFETCH] = events.read_prefetch;

		// A new event beats a clear in the same cycle
		state_next.flags = (state_next.flags | set_mask) & tag_regs_pkg::IRQ_BITS_MASK;
		state_next.irq = |(state_next.flags & state_next.irq_en);

		// Low-frequency tick and watchdog counter
		state_next.lf_div = (state_reg.lf_div == tag_regs_pkg::LF_DIV_CYCLES - 8'h01) ?
			8'h00 : state_reg.lf_div + 8'h01;
		if (!state_reg.wdt_ctrl[tag_regs_pkg::BIT_WDT_ENABLE]) begin
			state_next.wdt_cnt = '0;
		end else if (access_done && mapped(paddr) &&
			(!events.parity_mode_on || events.transfer_ok)) begin
			state_next.wdt_cnt = '0;
		end else if (wdt_expired) begin
			state_next.wdt_cnt = '0;
			state_next.dev_reset = 1'b1;
		end else if (state_reg.lf_div == 8'h00) begin
			state_next.wdt_cnt = state_reg.wdt_cnt + 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '{fsm: tag_regs_pkg::CRC_IDLE, crc_work: tag_regs_pkg::CRC_PRESET,
				default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : host_irq_crc_watchdog_regs

`default_nettype wire

/* bench/msg_memory_model.sv */
// Message memory model feeding bytes to the checksum engine.
// Assumes one read at a time; a byte is valid only the cycle after rd_en.
`timescale 1ns/1ps
`default_nettype none
module msg_memory_model (
	input wire logic                   pclk,     // Clock
	input wire tag_regs_pkg::mem_req_t mem_req,  // Read request
	output logic [7:0]                 mem_rdata // Byte a cycle later
);
	logic       valid = 1'b0;
	logic [7:0] data  = 8'h00;
	// Content is the scrambled low address byte
	always @(posedge pclk) begin
		valid <= mem_req.rd_en;
		if (mem_req.rd_en)
			data <= mem_req.addr[7:0] ^ 8'h5a;
	end
	// Outside the valid cycle the line shows the inverse, never a stale byte
	assign mem_rdata = valid ? data : ~data;
endmodule : msg_memory_model
`default_nettype wire

/* bench/tag_regs_checker_properties.sv */
// Port-level checks on the host register group, attached by bind.
// Assumes zero-wait APB and one byte fetched every two cycles.
`timescale 1ns/1ps
`default_nettype none
module tag_regs_checker #(
	parameter logic [7:0] VERSION_MAJOR = 8'h00, // Expected major field
	parameter logic [7:0] VERSION_MINOR = 8'h00  // Expected minor field
) (
	input wire logic                            pclk, // Clock
	input wire logic                            presetn, // Reset, low
	input wire logic                            psel, // Select
	input wire logic                            penable, // Access phase
	input wire logic                            pwrite, // Direction
	input wire logic [tag_regs_pkg::ADDR_W-1:0] paddr, // Address
	input wire logic [31:0]                     pwdata, // Write data
	input wire logic [3:0]                      pstrb, // Strobes
	input wire logic [31:0]                     prdata, // Read data
	input wire logic                            pready, // Ready
	input wire logic                            pslverr, // Error
	input wire tag_regs_pkg::engine_events_t    events, // Engine events
	input wire logic                            contactless_front_end_on, // Front end
	input wire tag_regs_pkg::mem_req_t          mem_req, // Memory request
	input wire logic [7:0]                      mem_rdata, // Memory byte
	input wire logic                            irq_out, // Interrupt
	input wire logic                            device_reset // Watchdog reset
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] idx;
	logic        acc;
	logic        rd_acc;
	logic        mapped;
	logic [15:0] start_sh;
	// Decoded access
	assign idx    = paddr[17:2];
	assign acc    = psel && penable;
	assign rd_acc = acc && !pwrite;
	assign mapped = paddr[1:0] == 2'b00 && idx[0] == 1'b0
		&& idx >= tag_regs_pkg::IDX_FIRMWARE_VERSION && idx <= tag_regs_pkg::IDX_BLOCK_STATUS;
	// Even start address last written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			start_sh <= 16'h0000;
		else if (acc && pwrite && mapped && idx == tag_regs_pkg::IDX_CHECKSUM_START)
			start_sh <= pwdata[15:0] & tag_regs_pkg::EVEN_MASK;
	end
	// ------------------------------
	// Checksum fetch steps
	// ------------------------------
	sequence s_start;
		acc && pwrite && mapped && idx == tag_regs_pkg::IDX_CHECKSUM_LENGTH && pstrb[1]
			&& pwdata[15:1] != 15'h0000 && !mem_req.rd_en && !$past(mem_req.rd_en);
	endsequence
	sequence s_step;
		mem_req.rd_en ##1 !(acc && pwrite && idx == tag_regs_pkg::IDX_CHECKSUM_LENGTH)
			##1 mem_req.rd_en;
	endsequence
	AST_ANSWER: assert property (acc |-> pready && pslverr == !mapped && prdata[31:16] == 16'h0000)
		else $error("access answer wrong");
	AST_FLAG_RESERVED: assert property (
		rd_acc && mapped && idx == tag_regs_pkg::IDX_INTERRUPT_FLAGS
		|-> prdata[2:0] == 3'h0 && prdata[15:9] == 7'h00) else $error("reserved flag bits set");
	AST_VERSION: assert property (
		rd_acc && mapped && idx == tag_regs_pkg::IDX_FIRMWARE_VERSION
		|-> prdata[15:0] == {VERSION_MAJOR, VERSION_MINOR}) else $error("version wrong");
	AST_CRC_START: assert property (
		s_start |=> mem_req.rd_en && mem_req.addr == start_sh) else $error("fetch start wrong");
	AST_FETCH_HOLD: assert property (
		mem_req.rd_en |=> !mem_req.rd_en && $stable(mem_req.addr)) else $error("fetch pace wrong");
	AST_FETCH_STEP: assert property (
		s_step |-> mem_req.addr == $past(mem_req.addr, 2) + 16'h0001) else $error("fetch step wrong");
	AST_RESET_PULSE: assert property (
		device_reset |=> !device_reset) else $error("reset pulse too long");
	AST_WDT_RESTART: assert property (
		acc && mapped && !events.parity_mode_on |-> ##2 !device_reset [*8])
		else $error("reset right after access");
	AST_IRQ_QUIET: assert property (
		rd_acc && mapped && idx == tag_regs_pkg::IDX_INTERRUPT_FLAGS && prdata[15:0] == 16'h0000
		|-> !irq_out) else $error("irq with no flag");
endmodule : tag_regs_checker
bind host_irq_crc_watchdog_regs tag_regs_checker #(
	.VERSION_MAJOR(VERSION_MAJOR),
	.VERSION_MINOR(VERSION_MINOR)
) props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .events(events), .contactless_front_end_on(contactless_front_end_on),
	.mem_req(mem_req), .mem_rdata(mem_rdata), .irq_out(irq_out), .device_reset(device_reset)
);
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench driving the host register group over APB.
// Assumes zero-wait APB, a 25 ns clock and shortened watchdog tick counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] VER_MAJOR = 8'h2c; // Arbitrary value
	localparam logic [7:0] VER_MINOR = 8'h71; // Arbitrary value
	tag_regs_pkg::engine_events_t ev = 8'h04;
	tag_regs_pkg::mem_req_t       mem_req;
	logic        pclk;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [17:0] paddr   = 18'h0_0000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [3:0]  pstrb   = 4'hf;
	logic        fe_on   = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq_out;
	logic        device_reset;
	logic [7:0]  mem_rdata;
	logic [31:0] rd;
	logic        err;
	int          failures    = 0;
	int          tests_run   = 0;
	int          resets_seen = 0;
	int          cyc         = 0;
	int          n;
	int          r;
	logic [7:0]  pv [8] = '{8'h84, 8'hc4, 8'h14, 8'h06, 8'h05, 8'h00, 8'h0c, 8'h00};
	logic [15:0] fx [8] = '{16'h0000, 16'h0010, 16'h0020, 16'h0080,
		16'h0100, 16'h0000, 16'h0000, 16'h0040};
	host_irq_crc_watchdog_regs #(
		.VERSION_MAJOR(VER_MAJOR), .VERSION_MINOR(VER_MINOR), .WDT_SHORT_TICKS(28'h000_0002),
		.WDT_MEDIUM_TICKS(28'h000_0003), .WDT_LONG_TICKS(28'h000_0004)
	) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .events(ev), .contactless_front_end_on(fe_on), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .irq_out(irq_out), .device_reset(device_reset)
	);
	msg_memory_model mem_model (.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
	// ------------------------------
	// Clock, counters and hang guard
	// ------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (device_reset === 1'b1)
			resets_seen <= resets_seen + 1;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		failures++;
		end_sim();
	end
	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic end_sim;
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] d);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {idx, 2'b00};
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			failures++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wdt_wait(input int t);
		int t0;
		int r0;
		t0 = cyc;
		r0 = resets_seen;
		while (resets_seen == r0 && cyc - t0 < (t + 1) * 156 + 8)
			@(posedge pclk);
		chk("wdt period", 32'h0000_0001, {31'h0, resets_seen != r0 && cyc - t0 > (t - 1) * 156});
	endtask : wdt_wait
	function automatic logic [15:0] crc_exp(input logic [15:0] len);
		logic [15:0] c;
		logic [7:0]  b;
		c = 16'hffff;
		for (int i = 0; i < int'(len & 16'hfffe); i++) begin
			b = (8'h10 + i[7:0]) ^ 8'h5a;
			c = c ^ {b, 8'h00};
			for (int j = 0; j < 8; j++)
				c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
		end
		return c;
	endfunction : crc_exp
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, tag_regs_pkg::IDX_COMM_WATCHDOG, 16'h0000);
		chk("wdt reset", 32'h0000_0000, rd);
		apb(1'b1, tag_regs_pkg::IDX_FIRMWARE_VERSION, 16'h0000);
		apb(1'b0, tag_regs_pkg::IDX_FIRMWARE_VERSION, 16'h0000);
		chk("version", {16'h0000, VER_MAJOR, VER_MINOR}, rd);
		apb(1'b0, 16'h1234, 16'h0000);
		chk("unmapped", 32'h0000_0001, {31'h0, err});
		// Odd start and length, then a zero length
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, tag_regs_pkg::IDX_CHECKSUM_START, 16'h0011);
			apb(1'b1, tag_regs_pkg::IDX_CHECKSUM_LENGTH, (i == 0) ? 16'h0007 : 16'h0000);
			apb(1'b0, tag_regs_pkg::IDX_BLOCK_STATUS, 16'h0000);
			chk("active", {31'h0, i == 0}, rd);
			n = 0;
			do begin
				apb(1'b0, tag_regs_pkg::IDX_INTERRUPT_FLAGS, 16'h0000);
				n++;
			end while (rd[3] !== 1'b1 && n < 20);
			chk("crc flag", 32'h0000_0008, rd);
			apb(1'b0, tag_regs_pkg::IDX_CHECKSUM_RESULT, 16'h0000);
			chk("crc", {16'h0000, crc_exp((i == 0) ? 16'h0007 : 16'h0000)}, rd);
			apb(1'b1, tag_regs_pkg::IDX_INTERRUPT_FLAGS, 16'h0000);
			apb(1'b0, tag_regs_pkg::IDX_INTERRUPT_FLAGS, 16'h0000);
			chk("flag kept", 32'h0000_0008, rd);
			apb(1'b1, tag_regs_pkg::IDX_INTERRUPT_FLAGS, 16'h0008);
		end
		fe_on <= 1'b1;
		apb(1'b0, tag_regs_pkg::IDX_BLOCK_STATUS, 16'h0000);
		chk("status", 32'h0000_0002, rd);
		apb(1'b1, tag_regs_pkg::IDX_INTERRUPT_ENABLE, 16'h01f8);
		// Each event alone, read, then cleared
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			ev <= pv[i];
			@(posedge pclk);
			ev <= 8'h04;
			apb(1'b0, tag_regs_pkg::IDX_INTERRUPT_FLAGS, 16'h0000);
			chk("flags", {16'h0000, fx[i]}, rd);
			chk("irq", {31'h0, fx[i] != 16'h0000}, {31'h0, irq_out});
			apb(1'b1, tag_regs_pkg::IDX_INTERRUPT_FLAGS, fx[i]);
			repeat (2) @(posedge pclk);
			chk("irq clear", 32'h0000_0000, {31'h0, irq_out});
		end
		// Timeout codes 0 to 3, idle host
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, tag_regs_pkg::IDX_COMM_WATCHDOG, {12'h000, c[2:0], 1'b1});
			wdt_wait((c == 1) ? 3 : (c == 2) ? 4 : 2);
		end
		// Busy host in parity mode, failing then passing transfers
		for (int k = 0; k < 2; k++) begin
			ev <= (k == 0) ? 8'h44 : 8'h64;
			apb(1'b1, tag_regs_pkg::IDX_COMM_WATCHDOG, 16'h0001);
			r = resets_seen;
			repeat (12) begin
				apb(1'b0, tag_regs_pkg::IDX_INTERRUPT_FLAGS, 16'h0000);
				repeat (40) @(posedge pclk);
			end
			chk("wdt parity", {31'h0, k == 0}, {31'h0, resets_seen != r});
		end
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, tag_regs_pkg::IDX_COMM_WATCHDOG, 16'h0000);
		chk("wdt reset", 32'h0000_0000, rd);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
